// ==== dv/mbrt_frame_handler_tb_top.sv ====
// self-checking bench: master model, register map model, frame table
`timescale 1ns/1ps
module mbrt_frame_handler_tb_top
  import mbrt_pkg::*;
;
  typedef struct {logic [111:0] req; int rn; logic [63:0] rsp; int en;} mbrt_row_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] station_id = 8'h01;
  logic legacy_coil = 1'b0;
  logic remote_ctrl = 1'b1;
  mbrt_byte_t rx_byte;
  logic rx_frame_end;
  mbrt_byte_t tx_byte;
  logic tx_ready;
  mbrt_map_req_t map_req;
  mbrt_map_info_t map_info;
  logic [15:0] map_rdata;
  logic [15:0] mem [0:255];
  logic coil_q = 1'b0;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  mbrt_row_t rows[18] = '{
    '{112'h0106_01f5_6666, 6, 64'h0106_01f5_6666, 6},
    '{112'h0103_01f5_0002, 6, 64'h0103_0466_66a5_f6, 7},
    '{112'h0103_01f7_0002, 6, 64'h0183_02, 3},
    '{112'h0101_0190_0001, 6, 64'h0101_0100, 4},
    '{112'h0105_0190_ff00, 6, 64'h0105_0190_ff00, 6},
    '{112'h0101_0190_0001, 6, 64'h0101_0101, 4},
    '{112'h0110_01f0_0002_0412_3456_78, 11, 64'h0110_01f0_0002, 6},
    '{112'h0103_01f0_0002, 6, 64'h0103_0412_3456_78, 7},
    '{112'h0110_01f7_0002_0411_1122_22, 11, 64'h0190_02, 3},
    '{112'h0103_01f7_0001, 6, 64'h0103_02a5_f7, 5},
    '{112'h0104_01f0_0001, 6, 64'h0184_01, 3},
    '{112'h0106_01f8_0001, 6, 64'h0186_01, 3},
    '{112'h0101_0190_0002, 6, 64'h0181_03, 3},
    '{112'h0103_01f0_0000, 6, 64'h0183_03, 3},
    '{112'h0106_01f5_6666_00, 7, 64'h0186_03, 3},
    '{112'h0103_0100_0001, 6, 64'h0183_02, 3},
    '{112'h0110_01f0_0002_0212_34, 9, 64'h0190_03, 3},
    '{112'h0103_01f0_007e, 6, 64'h0183_03, 3}
  };
  always #25 core_clk = ~core_clk;
  mbrt_frame_handler dut (.core_clk(core_clk), .nrst(nrst), .station_id(station_id),
    .legacy_coil(legacy_coil), .remote_ctrl(remote_ctrl), .rx_byte(rx_byte),
    .rx_frame_end(rx_frame_end), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .map_req(map_req), .map_info(map_info), .map_rdata(map_rdata));
  mbrt_master u_master (.core_clk(core_clk), .rx_byte(rx_byte),
    .rx_frame_end(rx_frame_end), .tx_ready(tx_ready), .tx_byte(tx_byte));
  ////////////////////////////////////////////////////////////////////////////////
  // map: read/write block 01f0-01f7, read-only block 01f8-01fb of another type
  always_comb
  begin
    map_info = '0;
    if (map_req.coil && map_req.addr == 16'h0190)
      map_info = '{1'b1, 5'h05, 3'h0, 16'h0190};
    else if (!map_req.coil && map_req.addr >= 16'h01f0 && map_req.addr <= 16'h01f7)
      map_info = '{1'b1, 5'h1a, 3'h1, 16'h01f7};
    else if (!map_req.coil && map_req.addr >= 16'h01f8 && map_req.addr <= 16'h01fb)
      map_info = '{1'b1, 5'h02, 3'h2, 16'h01fb};
  end
  assign map_rdata = map_req.coil ? {15'h0000, coil_q} : mem[map_req.addr[7:0]];
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = {8'ha5, i[7:0]};
  always @(posedge core_clk)
    if (map_req.wr === 1'b1 && map_req.coil)
      coil_q <= (map_req.wdata == 16'hff00);
    else if (map_req.wr === 1'b1)
      mem[map_req.addr[7:0]] <= map_req.wdata;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [111:0] r, input int rn, input bit bad, input bit stall,
    input logic [63:0] e, input int n);
    logic [7:0] q[$];
    logic [15:0] c;
    for (int i = rn - 1; i >= 0; i--)
      q.push_back(r[8*i +: 8]);
    u_master.send(q, bad);
    u_master.recv(stall);
    c = 16'hffff;
    foreach (u_master.rsp[i]) c = u_master.crc_step(c, u_master.rsp[i]);
    check(16'(u_master.rsp.size()), 16'(n == 0 ? 0 : n + 2));
    for (int i = 0; i < n && i < u_master.rsp.size(); i++)
      check({8'h00, u_master.rsp[i]}, {8'h00, e[8*(n-1-i) +: 8]});
    if (n > 0)
      check(c, 16'h0000);
    $display("test done at %0t", $time);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    foreach (rows[k])
      frame(rows[k].req, rows[k].rn, 1'b0, 1'b0, rows[k].rsp, rows[k].en);
    frame(112'h0106_01f5_66, 5, 1'b0, 1'b0, 64'h0186_03, 3);
    frame(112'h0106_01f5_1111, 6, 1'b1, 1'b0, 64'h0186_07, 3);
    legacy_coil <= 1'b1;
    frame(112'h0101_0190_0001, 6, 1'b0, 1'b0, 64'h0101_02ff_00, 5);
    frame(112'h0105_0190_0000, 6, 1'b0, 1'b0, 64'h0105_0190_0000, 6);
    frame(112'h0101_0190_0001, 6, 1'b0, 1'b0, 64'h0101_0200_00, 5);
    legacy_coil <= 1'b0;
    remote_ctrl <= 1'b0;
    frame(112'h0106_01f5_1111, 6, 1'b0, 1'b0, 64'h0186_04, 3);
    frame(112'h0110_01f0_0001_0299_99, 9, 1'b0, 1'b0, 64'h0190_04, 3);
    frame(112'h0105_0190_ff00, 6, 1'b0, 1'b0, 64'h0105_0190_ff00, 6);
    frame(112'h0103_01f5_0001, 6, 1'b0, 1'b1, 64'h0103_0266_66, 5);
    remote_ctrl <= 1'b1;
    frame(112'h0203_01f0_0001, 6, 1'b0, 1'b0, 64'h0, 0);
    station_id <= 8'h02;
    frame(112'h0203_01f0_0001, 6, 1'b0, 1'b1, 64'h0203_0212_34, 5);
    station_id <= 8'h01;
    // reset while a reply is going out: outputs drop, the next frame is served
    u_master.send('{8'h01, 8'h03, 8'h01, 8'hf0, 8'h00, 8'h02}, 1'b0);
    repeat (12) @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({15'h0000, tx_byte.valid}, 16'h0000);
    check({14'h0000, map_req.rd, map_req.wr}, 16'h0000);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    frame(112'h0103_01f0_0001, 6, 1'b0, 1'b0, 64'h0103_0212_34, 5);
    $display("reset test done at %0t", $time);
    summarize();
  end
endmodule

// ==== dv/mbrt_frame_monitor.sv ====
// port-level concurrent checks for the frame handler
`timescale 1ns/1ps
module mbrt_frame_monitor
  import mbrt_pkg::*;
#(
  parameter int BUF_DEPTH = 256
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] station_id,
  input wire logic legacy_coil,
  input wire logic remote_ctrl,
  input wire mbrt_byte_t rx_byte,
  input wire logic rx_frame_end,
  input wire mbrt_byte_t tx_byte,
  input wire logic tx_ready,
  input wire mbrt_map_req_t map_req,
  input wire mbrt_map_info_t map_info,
  input wire logic [15:0] map_rdata
);
  logic [8:0] rx_cnt_q;
  logic [8:0] rx_cnt_d;
  logic [7:0] rx_fn_q;
  logic [7:0] rx_fn_d;
  logic [8:0] tx_idx_q;
  logic [8:0] tx_idx_d;
  ////////////////////////////////////////////////////////////////////////////////
  // request function and reply byte position, restarted at each frame end
  always_comb
  begin
    rx_cnt_d = rx_frame_end ? 9'h000 : rx_cnt_q + {8'h00, rx_byte.valid};
    rx_fn_d = (rx_byte.valid && rx_cnt_q == 9'h001) ? rx_byte.data : rx_fn_q;
    tx_idx_d = rx_frame_end ? 9'h000 : tx_idx_q + {8'h00, tx_byte.valid & tx_ready};
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_cnt_q <= '0;
      rx_fn_q <= '0;
      tx_idx_q <= '0;
    end
    else
    begin
      rx_cnt_q <= rx_cnt_d;
      rx_fn_q <= rx_fn_d;
      tx_idx_q <= tx_idx_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  rst_quiet_a: assert property ($rose(nrst) |-> !tx_byte.valid && map_req == '0)
    else $error("outputs active right after reset");
  tx_hold_a: assert property (tx_byte.valid && !tx_ready |=>
    tx_byte.valid && $stable(tx_byte.data)) else $error("reply byte dropped or changed");
  head_echo_a: assert property (tx_byte.valid && tx_idx_q == 9'h000 |->
    tx_byte.data == station_id) else $error("reply head differs from station");
  fn_echo_a: assert property (tx_byte.valid && tx_idx_q == 9'h001 |->
    tx_byte.data == rx_fn_q || tx_byte.data == (rx_fn_q | 8'h80))
    else $error("reply function byte wrong");
  rd_pulse_a: assert property (map_req.rd |=> !map_req.rd)
    else $error("map read longer than one cycle");
  rd_wr_excl_a: assert property (map_req.wr |-> !map_req.rd)
    else $error("map read and write together");
  wr_remote_a: assert property (map_req.wr && !map_req.coil |-> remote_ctrl)
    else $error("register written without remote control");
  coil_value_a: assert property (map_req.wr && map_req.coil |->
    map_req.wdata == 16'hff00 || map_req.wdata == 16'h0000) else $error("bad coil value");
  wr_step_a: assert property (map_req.wr && $past(map_req.wr) |->
    map_req.addr == $past(map_req.addr) + 16'h0001) else $error("write address not stepping");
endmodule
bind mbrt_frame_handler mbrt_frame_monitor #(.BUF_DEPTH(BUF_DEPTH)) u_monitor
(
  .core_clk(core_clk), .nrst(nrst), .station_id(station_id), .legacy_coil(legacy_coil),
  .remote_ctrl(remote_ctrl), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
  .tx_byte(tx_byte), .tx_ready(tx_ready), .map_req(map_req), .map_info(map_info),
  .map_rdata(map_rdata)
);

// ==== dv/mbrt_master.sv ====
// remote master model: sends request frames, collects reply bytes
`timescale 1ns/1ps
module mbrt_master
  import mbrt_pkg::*;
(
  input wire logic core_clk,
  output mbrt_byte_t rx_byte,
  output logic rx_frame_end,
  output logic tx_ready,
  input wire mbrt_byte_t tx_byte
);
  logic [7:0] rsp[$];
  initial
  begin
    rx_byte = '0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    return r;
  endfunction
  // call just after a rising edge; bad flips one checksum bit
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) c = crc_step(c, q[i]);
    c[0] = c[0] ^ bad;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      rx_byte <= '{valid: 1'b1, data: q[i]};
      rx_frame_end <= (i == q.size() - 1);
      @(posedge core_clk);
    end
    // data line not left at the last value
    rx_byte <= '{valid: 1'b0, data: ~q[q.size() - 1]};
    rx_frame_end <= 1'b0;
  endtask
  // gathers bytes until 100 quiet cycles; stall toggles ready
  task automatic recv(input bit stall);
    int idle;
    rsp.delete();
    idle = 0;
    while (idle < 100)
    begin
      @(posedge core_clk);
      idle++;
      if (tx_byte.valid === 1'b1 && tx_ready === 1'b1)
      begin
        rsp.push_back(tx_byte.data);
        idle = 0;
      end
      tx_ready <= (stall && idle < 100) ? ~tx_ready : 1'b1;
    end
  endtask
endmodule

// ==== pkg/mbrt_map.svh ====
// constants for the binary frame handler: codes, limits, frame positions
`ifndef MBRT_MAP_SVH
`define MBRT_MAP_SVH
// Overview of operation
// - accepted queries get a data response; accepted writes get a byte echo
// - function code in byte 1 selects read/write and single/multiple access
// - coil read must ask exactly one coil; only that coil is read
// - legacy coil read answers two bytes, 0xFF00 true or 0x0000 false
// - current coil read answers one data byte for one coil
// - holding read returns n consecutive registers, two bytes each
// - multi read may cross groups only while data type stays equal
// - holding read carries address bytes 2-3, count 4-5, count 1 to 125
// - single coil write data is 0x0000 false or 0xFF00 true
// - single register write has address 2-3, value 4-5, checksum 6-7
// - multi write byte count in byte 6 equals twice register count
// - multi write beyond the end of its register block is rejected
// - fields go most significant byte first, checksum low byte first
// - write length checked against target size; checksum right after data
// - wrong length misplaces the checksum, so an error frame is returned
// - queries are answered at once with fixed construction per function
// - every register is one 16-bit unit of two bytes
// - only functions assigned to a register are accepted on it
// - error reply is function plus 0x80, one error code, checksum
// - register writes are carried out only under remote control; single coil writes also without it
// - checksum is the ModBus CRC, byte order reversed in the frame
`define MBRT_FN_RC 8'h01
`define MBRT_FN_RHR 8'h03
`define MBRT_FN_WSC 8'h05
`define MBRT_FN_WSR 8'h06
`define MBRT_FN_WMR 8'h10
`define MBRT_EXC_FLAG 8'h80
`define MBRT_ERR_FUNC 8'h01
`define MBRT_ERR_ADDR 8'h02
`define MBRT_ERR_VALUE 8'h03
`define MBRT_ERR_LOCAL 8'h04
`define MBRT_ERR_CRC 8'h07
`define MBRT_BIT_RC 3'h0
`define MBRT_BIT_RHR 3'h1
`define MBRT_BIT_WSC 3'h2
`define MBRT_BIT_WSR 3'h3
`define MBRT_BIT_WMR 3'h4
`define MBRT_COIL_TRUE 16'hff00
`define MBRT_COIL_FALSE 16'h0000
`define MBRT_RHR_MAX 16'h007d
`define MBRT_WMR_MAX 16'h007b
`define MBRT_LEN_MIN 9'h002
`define MBRT_LEN_FIXED 9'h008
`define MBRT_LEN_WMR_BASE 9'h009
`define MBRT_LEN_ECHO 9'h006
`define MBRT_RSP_HDR 9'h003
`define MBRT_COIL_LEN_OLD 8'h02
`define MBRT_COIL_LEN_NEW 8'h01
`define MBRT_POS_CNT 8'h02
`define MBRT_POS_RDATA 8'h03
`define MBRT_POS_WDATA 8'h07
`define MBRT_CRC_INIT 16'hffff
`define MBRT_CRC_POLY 16'ha001
`endif

// ==== pkg/mbrt_pkg.sv ====
// shared types of the binary frame handler
package mbrt_pkg;
  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
  } mbrt_byte_t;

  typedef struct packed
  {
    logic present;
    logic [4:0] fn_mask;
    logic [2:0] dtype;
    logic [15:0] blk_last;
  } mbrt_map_info_t;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic coil;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbrt_map_req_t;

  typedef enum logic [2:0]
  {
    ST_RX,
    ST_CHECK,
    ST_VAL_ADDR,
    ST_VAL_CHK,
    ST_EXEC,
    ST_RESP,
    ST_SEND
  } mbrt_state_t;
endpackage

// ==== src/mbrt_crc16.sv ====
// running checksum over a byte stream, one byte per cycle
`timescale 1ns/1ps
`include "mbrt_map.svh"
module mbrt_crc16
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  always_comb
  begin
    crc_d = crc_q ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ `MBRT_CRC_POLY) : (crc_d >> 1);
    end
    if (clr)
    begin
      crc_d = `MBRT_CRC_INIT;
    end
    else if (!en)
    begin
      crc_d = crc_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crc_q <= `MBRT_CRC_INIT;
    end
    else
    begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule

// ==== src/mbrt_frame_handler.sv ====
// slave frame handler: receive, validate, execute and answer binary frames
`timescale 1ns/1ps
`include "mbrt_map.svh"
module mbrt_frame_handler
  import mbrt_pkg::*;
#(
  parameter int BUF_DEPTH = 256
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] station_id,
  input wire logic legacy_coil,
  input wire logic remote_ctrl,
  input wire mbrt_byte_t rx_byte,
  input wire logic rx_frame_end,
  output mbrt_byte_t tx_byte,
  input wire logic tx_ready,
  output mbrt_map_req_t map_req,
  input wire mbrt_map_info_t map_info,
  input wire logic [15:0] map_rdata
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int CW = AW + 1;
  localparam logic [15:0] COIL_T = `MBRT_COIL_TRUE;
  localparam logic [15:0] COIL_F = `MBRT_COIL_FALSE;

  ////////////////////////////////////////////////////////////////////////////
  mbrt_state_t st_q, st_d;
  logic [7:0] rxb [BUF_DEPTH];
  logic [7:0] txb [BUF_DEPTH];
  logic [CW-1:0] rx_cnt_q, rx_cnt_d;
  logic ovf_q, ovf_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] loop_n_q, loop_n_d;
  logic [2:0] dtype_q, dtype_d;
  logic [7:0] err_q, err_d;
  logic [7:0] rsp_fn_q, rsp_fn_d;
  logic echo_q, echo_d;
  logic [CW-1:0] tx_len_q, tx_len_d;
  logic [CW-1:0] tx_idx_q, tx_idx_d;
  mbrt_map_req_t req_q, req_d;
  logic rx_we;
  logic t0_we, t1_we;
  logic [AW-1:0] t0_wa, t1_wa;
  logic [7:0] t0_wd, t1_wd;
  logic rx_crc_clr, rx_crc_en;
  logic tx_crc_clr, tx_crc_en;
  logic [15:0] rx_crc, tx_crc;
  logic tx_load, tx_busy;
  logic [7:0] tx_ld_data;
  logic [7:0] fn;
  logic [15:0] addr, num;
  logic [7:0] bcnt;
  logic [2:0] fn_bit;
  logic is_write;
  logic [16:0] wmr_end;
  logic [AW-1:0] rd_pos;
  logic [AW-1:0] wr_pos;

  // fixed frame fields, most significant byte first
  assign fn = rxb[1];
  assign addr = {rxb[2], rxb[3]};
  assign num = {rxb[4], rxb[5]};
  assign bcnt = rxb[6];
  assign is_write = (fn == `MBRT_FN_WSC) || (fn == `MBRT_FN_WSR) || (fn == `MBRT_FN_WMR);
  assign wmr_end = {1'b0, addr} + {1'b0, num} - 17'h00001;
  assign rd_pos = AW'(`MBRT_POS_RDATA) + AW'({idx_q, 1'b0});
  assign wr_pos = AW'(`MBRT_POS_WDATA) + AW'({idx_q, 1'b0});
  // the receive checksum restarts whenever the block returns to listening
  assign rx_crc_clr = (st_d == ST_RX) && (st_q != ST_RX);

  always_comb
  begin
    case (fn)
      `MBRT_FN_RC: fn_bit = `MBRT_BIT_RC;
      `MBRT_FN_RHR: fn_bit = `MBRT_BIT_RHR;
      `MBRT_FN_WSC: fn_bit = `MBRT_BIT_WSC;
      `MBRT_FN_WSR: fn_bit = `MBRT_BIT_WSR;
      default: fn_bit = `MBRT_BIT_WMR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    rx_cnt_d = rx_cnt_q;
    ovf_d = ovf_q;
    idx_d = idx_q;
    loop_n_d = loop_n_q;
    dtype_d = dtype_q;
    err_d = err_q;
    rsp_fn_d = rsp_fn_q;
    echo_d = echo_q;
    tx_len_d = tx_len_q;
    tx_idx_d = tx_idx_q;
    req_d = req_q;
    req_d.rd = 1'b0;
    req_d.wr = 1'b0;
    rx_we = 1'b0;
    rx_crc_en = 1'b0;
    t0_we = 1'b0;
    t0_wa = '0;
    t0_wd = 8'h00;
    t1_we = 1'b0;
    t1_wa = '0;
    t1_wd = 8'h00;
    tx_crc_clr = 1'b0;
    tx_crc_en = 1'b0;
    tx_load = 1'b0;
    tx_ld_data = 8'h00;
    case (st_q)
      ST_RX:
      begin
        if (rx_byte.valid)
        begin
          rx_crc_en = 1'b1;
          if (rx_cnt_q < CW'(BUF_DEPTH))
          begin
            rx_we = 1'b1;
            rx_cnt_d = rx_cnt_q + CW'(1);
          end
          else
          begin
            ovf_d = 1'b1;
          end
        end
        if (rx_frame_end)
        begin
          st_d = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        idx_d = 8'h00;
        err_d = 8'h00;
        rsp_fn_d = fn;
        loop_n_d = 8'h01;
        st_d = ST_VAL_ADDR;
        if (rx_cnt_q < CW'(`MBRT_LEN_MIN) || rxb[0] != station_id)
        begin
          st_d = ST_RX;
        end
        else
        begin
          // a whole frame with its trailing checksum leaves zero behind
          if (ovf_q || rx_crc != 16'h0000)
          begin
            err_d = `MBRT_ERR_CRC;
          end
          else
          begin
            case (fn)
              `MBRT_FN_RC:
              begin
                if (rx_cnt_q != CW'(`MBRT_LEN_FIXED) || num != 16'h0001)
                begin
                  err_d = `MBRT_ERR_VALUE;
                end
              end
              `MBRT_FN_RHR:
              begin
                loop_n_d = num[7:0];
                if (rx_cnt_q != CW'(`MBRT_LEN_FIXED) || num == 16'h0000 ||
                    num > `MBRT_RHR_MAX)
                begin
                  err_d = `MBRT_ERR_VALUE;
                end
              end
              `MBRT_FN_WSC:
              begin
                if (rx_cnt_q != CW'(`MBRT_LEN_FIXED) || (num != COIL_T && num != COIL_F))
                begin
                  err_d = `MBRT_ERR_VALUE;
                end
              end
              `MBRT_FN_WSR:
              begin
                if (rx_cnt_q != CW'(`MBRT_LEN_FIXED))
                begin
                  err_d = `MBRT_ERR_VALUE;
                end
              end
              `MBRT_FN_WMR:
              begin
                loop_n_d = num[7:0];
                if (rx_cnt_q != CW'(`MBRT_LEN_WMR_BASE) + CW'(bcnt) ||
                    {8'h00, bcnt} != {num[14:0], 1'b0} || num == 16'h0000 ||
                    num > `MBRT_WMR_MAX)
                begin
                  err_d = `MBRT_ERR_VALUE;
                end
              end
              default: err_d = `MBRT_ERR_FUNC;
            endcase
            // the coil write stays open so that remote control can be taken
            if (err_d == 8'h00 && !remote_ctrl && is_write && fn != `MBRT_FN_WSC)
            begin
              err_d = `MBRT_ERR_LOCAL;
            end
          end
          if (err_d != 8'h00)
          begin
            st_d = ST_RESP;
          end
        end
      end
      ST_VAL_ADDR:
      begin
        req_d.rd = 1'b1;
        req_d.coil = (fn == `MBRT_FN_RC) || (fn == `MBRT_FN_WSC);
        req_d.addr = addr + 16'(idx_q);
        st_d = ST_VAL_CHK;
      end
      ST_VAL_CHK:
      begin
        if (idx_q == 8'h00)
        begin
          dtype_d = map_info.dtype;
        end
        if (!map_info.present)
        begin
          err_d = `MBRT_ERR_ADDR;
        end
        else if (!map_info.fn_mask[fn_bit])
        begin
          err_d = `MBRT_ERR_FUNC;
        end
        else if (idx_q != 8'h00 && map_info.dtype != dtype_q)
        begin
          err_d = `MBRT_ERR_ADDR;
        end
        else if (fn == `MBRT_FN_WMR && wmr_end > {1'b0, map_info.blk_last})
        begin
          err_d = `MBRT_ERR_ADDR;
        end
        if (fn == `MBRT_FN_RHR)
        begin
          t0_we = 1'b1;
          t0_wa = rd_pos;
          t0_wd = map_rdata[15:8];
          t1_we = 1'b1;
          t1_wa = rd_pos + AW'(1);
          t1_wd = map_rdata[7:0];
        end
        else if (fn == `MBRT_FN_RC)
        begin
          t0_we = 1'b1;
          t0_wa = AW'(`MBRT_POS_RDATA);
          t1_we = legacy_coil;
          t1_wa = AW'(`MBRT_POS_RDATA) + AW'(1);
          if (legacy_coil)
          begin
            t0_wd = (map_rdata != 16'h0000) ? COIL_T[15:8] : COIL_F[15:8];
            t1_wd = (map_rdata != 16'h0000) ? COIL_T[7:0] : COIL_F[7:0];
          end
          else
          begin
            t0_wd = {7'h00, map_rdata != 16'h0000};
          end
        end
        idx_d = idx_q + 8'h01;
        if (err_d != 8'h00 || idx_q + 8'h01 == loop_n_q)
        begin
          idx_d = 8'h00;
          st_d = (err_d == 8'h00 && is_write) ? ST_EXEC : ST_RESP;
        end
        else
        begin
          st_d = ST_VAL_ADDR;
        end
      end
      ST_EXEC:
      begin
        // every register passed checking first, so a bad frame writes nothing
        req_d.wr = 1'b1;
        req_d.addr = addr + 16'(idx_q);
        req_d.wdata = (fn == `MBRT_FN_WMR) ? {rxb[wr_pos], rxb[wr_pos + AW'(1)]} : num;
        idx_d = idx_q + 8'h01;
        if (idx_q + 8'h01 == loop_n_q)
        begin
          st_d = ST_RESP;
        end
      end
      ST_RESP:
      begin
        tx_crc_clr = 1'b1;
        tx_idx_d = '0;
        echo_d = 1'b0;
        t0_we = 1'b1;
        t0_wa = AW'(`MBRT_POS_CNT);
        if (err_d != 8'h00)
        begin
          rsp_fn_d = fn | `MBRT_EXC_FLAG;
          t0_wd = err_q;
          tx_len_d = CW'(`MBRT_RSP_HDR);
        end
        else if (is_write)
        begin
          t0_we = 1'b0;
          echo_d = 1'b1;
          tx_len_d = CW'(`MBRT_LEN_ECHO);
        end
        else if (fn == `MBRT_FN_RC)
        begin
          t0_wd = legacy_coil ? `MBRT_COIL_LEN_OLD : `MBRT_COIL_LEN_NEW;
          tx_len_d = CW'(`MBRT_RSP_HDR) + CW'(t0_wd);
        end
        else
        begin
          t0_wd = {num[6:0], 1'b0};
          tx_len_d = CW'(`MBRT_RSP_HDR) + CW'(t0_wd);
        end
        st_d = ST_SEND;
      end
      ST_SEND:
      begin
        if (!tx_busy)
        begin
          tx_load = 1'b1;
          tx_idx_d = tx_idx_q + CW'(1);
          if (tx_idx_q < tx_len_q)
          begin
            tx_crc_en = 1'b1;
            if (echo_q || tx_idx_q == CW'(0))
            begin
              tx_ld_data = rxb[tx_idx_q[AW-1:0]];
            end
            else if (tx_idx_q == CW'(1))
            begin
              tx_ld_data = rsp_fn_q;
            end
            else
            begin
              tx_ld_data = txb[tx_idx_q[AW-1:0]];
            end
          end
          else if (tx_idx_q == tx_len_q)
          begin
            tx_ld_data = tx_crc[7:0];
          end
          else
          begin
            tx_ld_data = tx_crc[15:8];
            st_d = ST_RX;
          end
        end
      end
      default: st_d = ST_RX;
    endcase
    if (st_d == ST_RX && st_q != ST_RX)
    begin
      rx_cnt_d = '0;
      ovf_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_RX;
      rx_cnt_q <= '0;
      ovf_q <= 1'b0;
      idx_q <= 8'h00;
      loop_n_q <= 8'h00;
      dtype_q <= 3'h0;
      err_q <= 8'h00;
      rsp_fn_q <= 8'h00;
      echo_q <= 1'b0;
      tx_len_q <= '0;
      tx_idx_q <= '0;
      req_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      rx_cnt_q <= rx_cnt_d;
      ovf_q <= ovf_d;
      idx_q <= idx_d;
      loop_n_q <= loop_n_d;
      dtype_q <= dtype_d;
      err_q <= err_d;
      rsp_fn_q <= rsp_fn_d;
      echo_q <= echo_d;
      tx_len_q <= tx_len_d;
      tx_idx_q <= tx_idx_d;
      req_q <= req_d;
    end
  end

  // frame stores carry no reset; nothing reads them before they are written
  always_ff @(posedge core_clk)
  begin
    if (rx_we)
    begin
      rxb[rx_cnt_q[AW-1:0]] <= rx_byte.data;
    end
    if (t0_we)
    begin
      txb[t0_wa] <= t0_wd;
    end
    if (t1_we)
    begin
      txb[t1_wa] <= t1_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  mbrt_crc16 u_rx_crc
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .clr(rx_crc_clr),
    .en(rx_crc_en),
    .data(rx_byte.data),
    .crc(rx_crc)
  );

  mbrt_crc16 u_tx_crc
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .clr(tx_crc_clr),
    .en(tx_crc_en),
    .data(tx_ld_data),
    .crc(tx_crc)
  );

  mbrt_tx_port u_tx
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(tx_load),
    .data(tx_ld_data),
    .tx_ready(tx_ready),
    .busy(tx_busy),
    .tx_byte(tx_byte)
  );

  assign map_req = req_q;
endmodule

// ==== src/mbrt_tx_port.sv ====
// one-byte output stage with valid/ready hand-off
`timescale 1ns/1ps
module mbrt_tx_port
  import mbrt_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic tx_ready,
  output logic busy,
  output mbrt_byte_t tx_byte
);
  mbrt_byte_t out_q;
  mbrt_byte_t out_d;

  always_comb
  begin
    out_d = out_q;
    if (out_q.valid && tx_ready)
    begin
      out_d.valid = 1'b0;
    end
    // load is only raised while idle, so no byte is overwritten
    if (load)
    begin
      out_d.valid = 1'b1;
      out_d.data = data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign busy = out_q.valid;
  assign tx_byte = out_q;
endmodule
